// [hw/mis_sequencer.sv]
`include "mis_regs.svh"
`default_nettype none
module mis_sequencer #(
    parameter logic [15:0] TMR_VEC = 16'h0000,
    parameter logic [15:0] RTC_VEC = 16'h0000,
    parameter logic [15:0] SPI_VEC = 16'h0000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Avalon-MM register slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External pins, active low
    input wire logic req_n,
    input wire logic ext_line_a_n,
    input wire logic ext_line_b_n,
    // Peripheral requests, already gated by their own enables, then the RTC-in-use flag for stop
    input wire logic tmr_req,
    input wire logic rtc_req,
    input wire logic spi_req,
    input wire logic rtc_int_used,
    // Peripheral clear sequence (0 timer, 1 serial port)
    input wire logic [1:0] periph_flag,
    input wire logic [1:0] periph_status_rd,
    input wire logic [1:0] periph_assoc_acc,
    output logic [1:0] periph_flag_clr,
    // Instruction sequencer
    input wire mis_pkg::mis_cpu_cmd_s cpu_cmd,
    output mis_pkg::mis_seq_s seq
);
    import mis_pkg::*;

    // =====================================================
    // Pin synchronisers and falling-edge detection.
    logic [2:0] pins_n;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] prev_q;
    logic [2:0] fall;
    assign pins_n = {ext_line_b_n, ext_line_a_n, req_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                    prev_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi] <= pins_n[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi] <= sync2_q[gi];
                end
            end
            assign fall[gi] = prev_q[gi] & ~sync2_q[gi];
        end
    endgenerate

    // =====================================================
    // Registers.
    logic [7:0] enable_q;
    logic [2:0] misc_q;
    logic flag_a_q;
    logic flag_b_q;
    logic ack_q;
    logic access;
    logic [7:0] word_idx;
    logic wr_en;
    logic wr_st;
    logic wr_mc;
    logic [7:0] status;
    logic edge_only_req;
    logic edge_only_a;
    logic edge_only_b;

    assign access = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign word_idx = avs_address[9:2];
    // Writes land on the completing edge, so a master that abandons a
    // request while it is still waiting leaves no trace.
    assign wr_en = ack_q & avs_write & avs_byteenable[0] &
                   (word_idx == `MIS_IDX_ENABLE);
    assign wr_st = ack_q & avs_write & avs_byteenable[0] &
                   (word_idx == `MIS_IDX_STATUS);
    assign wr_mc = ack_q & avs_write & avs_byteenable[0] &
                   (word_idx == `MIS_IDX_MISC);
    assign edge_only_req = misc_q[`MIS_MC_REQ_EDGE - 5];
    assign edge_only_a = misc_q[`MIS_MC_LINE_A_EDGE - 5];
    assign edge_only_b = misc_q[`MIS_MC_LINE_B_EDGE - 5];

    always_comb begin
        status = 8'h00;
        status[`MIS_ST_FLAG_B] = flag_b_q;
        status[`MIS_ST_FLAG_A] = flag_a_q;
        status[`MIS_ST_LEVEL_B] = sync2_q[2];
        status[`MIS_ST_LEVEL_A] = sync2_q[1];
    end

    // One wait state: every access is answered on the second edge.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (access && avs_read) begin
            case (word_idx)
                `MIS_IDX_ENABLE: avs_readdata <= {24'h000000, enable_q};
                `MIS_IDX_STATUS: avs_readdata <= {24'h000000, status};
                `MIS_IDX_MISC: avs_readdata <= {24'h000000, misc_q, 5'h00};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Only bits 7 and 6 exist; the rest read as zero.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= `MIS_RST_ENABLE;
        end else if (wr_en) begin
            enable_q <= avs_writedata[7:0] & 8'hc0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            misc_q <= `MIS_RST_MISC;
        end else if (wr_mc) begin
            misc_q <= avs_writedata[7:5];
        end
    end

    // =====================================================
    // Line flags: event sets, write-one clears, set wins.
    logic set_a;
    logic set_b;
    assign set_a = fall[1] | (~edge_only_a & ~sync2_q[1]);
    assign set_b = fall[2] | (~edge_only_b & ~sync2_q[2]);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else begin
            if (set_a) begin
                flag_a_q <= 1'b1;
            end else if (wr_st && avs_writedata[`MIS_ST_FLAG_A]) begin
                flag_a_q <= 1'b0;
            end
            if (set_b) begin
                flag_b_q <= 1'b1;
            end else if (wr_st && avs_writedata[`MIS_ST_FLAG_B]) begin
                flag_b_q <= 1'b0;
            end
        end
    end

    // =====================================================
    // Peripheral flag clear: status read while set, then access.
    logic [1:0] armed_q;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_clr
            assign periph_flag_clr[gi] = armed_q[gi] &
                                         periph_assoc_acc[gi];
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    armed_q[gi] <= 1'b0;
                end else if (periph_status_rd[gi]) begin
                    armed_q[gi] <= periph_flag[gi];
                end else if (periph_assoc_acc[gi]) begin
                    armed_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // =====================================================
    // Request line latch and pending sources.
    mis_state_e state_q;
    mis_src_e src_q;
    logic req_latch_q;
    logic mask_q;
    logic [15:0] vector_q;
    logic [6:0] pend;
    logic any_pend;
    logic take_ok;
    logic ext_wake;
    mis_src_e win;
    logic [15:0] win_vec;

    // Cleared while the state is pushed for SRC_REQ, so one more pulse may land.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            req_latch_q <= 1'b0;
        end else if (fall[0]) begin
            req_latch_q <= 1'b1;
        end else if (state_q == S_PUSH && src_q == SRC_REQ) begin
            req_latch_q <= 1'b0;
        end
    end

    // Bit index follows priority: 6 is the highest vector.
    assign pend[6] = req_latch_q | (~edge_only_req & ~sync2_q[0]);
    assign pend[5] = flag_a_q & enable_q[`MIS_EN_LINE_A];
    assign pend[4] = tmr_req;
    assign pend[3] = flag_b_q & enable_q[`MIS_EN_LINE_B];
    assign pend[2] = rtc_req;
    assign pend[1] = spi_req;
    assign pend[0] = 1'b0;
    assign any_pend = |pend[6:1];
    assign take_ok = any_pend & ~mask_q;
    assign ext_wake = pend[6] | pend[5] | pend[3];

    always_comb begin
        win = SRC_SPI;
        win_vec = SPI_VEC;
        if (pend[6]) begin
            win = SRC_REQ;
            win_vec = `MIS_VEC_REQ;
        end else if (pend[5]) begin
            win = SRC_A;
            win_vec = `MIS_VEC_LINE_A;
        end else if (pend[4]) begin
            win = SRC_TMR;
            win_vec = TMR_VEC;
        end else if (pend[3]) begin
            win = SRC_B;
            win_vec = `MIS_VEC_LINE_B;
        end else if (pend[2]) begin
            win = SRC_RTC;
            win_vec = RTC_VEC;
        end
    end

    // =====================================================
    // Sequencer.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_LOAD;
            src_q <= SRC_TRAP;
            vector_q <= `MIS_VEC_RESET;
        end else begin
            case (state_q)
                S_RUN: begin
                    if (cpu_cmd.instr_end) begin
                        if (cpu_cmd.soft_trap) begin
                            state_q <= S_PUSH;
                            src_q <= SRC_TRAP;
                            vector_q <= `MIS_VEC_TRAP;
                        end else if (take_ok) begin
                            state_q <= S_PUSH;
                            src_q <= win;
                            vector_q <= win_vec;
                        end else if (cpu_cmd.stop) begin
                            state_q <= S_STOP;
                        end else if (cpu_cmd.wait_req) begin
                            state_q <= S_WAIT;
                        end
                    end
                end
                S_PUSH: state_q <= S_LOAD;
                S_LOAD: state_q <= S_RUN;
                S_STOP, S_WAIT: begin
                    if ((state_q == S_STOP) ? ext_wake : any_pend) begin
                        if (take_ok) begin
                            state_q <= S_PUSH;
                            src_q <= win;
                            vector_q <= win_vec;
                        end else begin
                            state_q <= S_RUN;
                        end
                    end
                end
                default: state_q <= S_RUN;
            endcase
        end
    end

    // The mask stays set from reset until software clears it.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mask_q <= 1'b1;
        end else if (state_q == S_PUSH) begin
            mask_q <= 1'b1;
        end else if (state_q == S_RUN && cpu_cmd.instr_end &&
                     cpu_cmd.return_from_handler) begin
            mask_q <= cpu_cmd.stacked_mask;
        end
    end

    always_comb begin
        seq.push = (state_q == S_PUSH);
        seq.load_pc = (state_q == S_LOAD);
        seq.vector = vector_q;
        seq.mask = mask_q;
        seq.cpu_clk_run = (state_q != S_STOP) && (state_q != S_WAIT);
        seq.osc_run = !(state_q == S_STOP && rtc_int_used);
        seq.busy = (state_q != S_RUN);
    end

    // =====================================================
    // Checks.
    logic end_plain;
    assign end_plain = state_q == S_RUN && cpu_cmd.instr_end &&
                       !cpu_cmd.soft_trap;

    property p_mask_blocks;
        @(posedge core_clk) disable iff (!resetn)
        end_plain && mask_q |=> state_q != S_PUSH;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked interrupt taken");

    property p_trap_any;
        @(posedge core_clk) disable iff (!resetn)
        state_q == S_RUN && cpu_cmd.instr_end && cpu_cmd.soft_trap
        |=> seq.push && vector_q == `MIS_VEC_TRAP ##1 seq.load_pc;
    endproperty
    a_trap_any: assert property (p_trap_any)
        else $error("trap not taken");

    property p_push_load;
        @(posedge core_clk) disable iff (!resetn)
        seq.push |=> seq.load_pc && mask_q && $stable(vector_q);
    endproperty
    a_push_load: assert property (p_push_load)
        else $error("push not followed by masked load");

    property p_only_at_end;
        @(posedge core_clk) disable iff (!resetn)
        state_q == S_RUN && !cpu_cmd.instr_end |=> state_q != S_PUSH;
    endproperty
    a_only_at_end: assert property (p_only_at_end)
        else $error("interrupt taken mid instruction");

    property p_ret_mask;
        @(posedge core_clk) disable iff (!resetn)
        end_plain && cpu_cmd.return_from_handler
        |=> mask_q == $past(cpu_cmd.stacked_mask);
    endproperty
    a_ret_mask: assert property (p_ret_mask)
        else $error("mask not restored from stack");

    property p_enable_gate;
        @(posedge core_clk) disable iff (!resetn)
        end_plain && take_ok && !enable_q[`MIS_EN_LINE_A]
        |=> vector_q != `MIS_VEC_LINE_A;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("disabled line pending");

    property p_set_wins;
        @(posedge core_clk) disable iff (!resetn)
        set_a && wr_st && avs_writedata[`MIS_ST_FLAG_A] |=> flag_a_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("line flag event lost to clear");

    property p_prio;
        @(posedge core_clk) disable iff (!resetn)
        end_plain && take_ok && pend[6]
        |=> vector_q == `MIS_VEC_REQ;
    endproperty
    a_prio: assert property (p_prio)
        else $error("wrong priority");

    property p_stop_osc;
        @(posedge core_clk) disable iff (!resetn)
        state_q == S_STOP |-> !seq.cpu_clk_run &&
                              seq.osc_run == !rtc_int_used;
    endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("stop clock gating wrong");

    property p_periph_clr;
        @(posedge core_clk) disable iff (!resetn)
        periph_status_rd[0] && periph_flag[0] ##1
        periph_assoc_acc[0] && !periph_status_rd[0]
        |-> periph_flag_clr[0];
    endproperty
    a_periph_clr: assert property (p_periph_clr)
        else $error("peripheral clear missed");

    c_take: cover property (@(posedge core_clk) disable iff (!resetn)
        seq.push ##1 seq.load_pc);
    c_wait_wake: cover property (@(posedge core_clk)
        disable iff (!resetn) state_q == S_WAIT ##1 state_q == S_PUSH);
    c_stop_wake: cover property (@(posedge core_clk)
        disable iff (!resetn) state_q == S_STOP ##1 state_q == S_RUN);
endmodule
`default_nettype wire

// [hw/mis_regs.svh]
`ifndef MIS_REGS_SVH
`define MIS_REGS_SVH
// =====================================================
// Register indices (byte address is four times these).
`define MIS_IDX_ENABLE 8'h25
`define MIS_IDX_STATUS 8'h26
`define MIS_IDX_MISC 8'h27
// =====================================================
// Field positions.
`define MIS_EN_LINE_B 7
`define MIS_EN_LINE_A 6
`define MIS_ST_FLAG_B 7
`define MIS_ST_FLAG_A 6
`define MIS_ST_LEVEL_B 1
`define MIS_ST_LEVEL_A 0
`define MIS_MC_LINE_B_EDGE 7
`define MIS_MC_LINE_A_EDGE 6
`define MIS_MC_REQ_EDGE 5
// =====================================================
// Reset values.
`define MIS_RST_ENABLE 8'h00
`define MIS_RST_MISC 3'h0
// =====================================================
// Vector pairs (address of the high byte).
`define MIS_VEC_RESET 16'h3ffe
`define MIS_VEC_TRAP 16'h3ffc
`define MIS_VEC_REQ 16'h3ffa
`define MIS_VEC_LINE_A 16'h3ff8
`define MIS_VEC_LINE_B 16'h3ff4
`endif

// [hw/mis_pkg.sv]
`default_nettype none
package mis_pkg;
    typedef enum logic [2:0] {
        S_RUN, S_PUSH, S_LOAD, S_STOP, S_WAIT
    } mis_state_e;
    typedef enum logic [2:0] {
        SRC_TRAP, SRC_REQ, SRC_A, SRC_TMR, SRC_B, SRC_RTC, SRC_SPI
    } mis_src_e;
    typedef struct packed {
        logic instr_end;
        logic soft_trap;
        logic return_from_handler;
        logic stacked_mask;
        logic stop;
        logic wait_req;
    } mis_cpu_cmd_s;
    typedef struct packed {
        logic push;
        logic load_pc;
        logic [15:0] vector;
        logic mask;
        logic cpu_clk_run;
        logic osc_run;
        logic busy;
    } mis_seq_s;
endpackage
`default_nettype wire

// [bench/mis_cpu_model.sv]
`default_nettype none
module mis_cpu_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Sequencer link
    input wire mis_pkg::mis_seq_s seq,
    output mis_pkg::mis_cpu_cmd_s cpu_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    import mis_pkg::*;
    // =====================================================
    // Instruction boundary.
    initial cpu_cmd = '0;
    // Qualifiers are scrambled between boundaries, since the
    // sequencer must only look at them alongside instr_end.
    task automatic run_instr(input logic [4:0] k, input int gap);
        int n;
        n = 0;
        repeat (gap) @(posedge core_clk);
        do begin
            @(posedge core_clk);
            n++;
        end while ((seq.busy !== 1'b0 || resetn !== 1'b1) && n < 100);
        cpu_cmd <= {1'b1, k};
        @(posedge core_clk);
        cpu_cmd <= {1'b0, ~k};
    endtask
endmodule
`default_nettype wire

// [bench/mcu_interrupt_sequencer_tb_top.sv]
`include "mis_regs.svh"
`default_nettype none
module mcu_interrupt_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mis_pkg::*;
    localparam logic [7:0] en_i = `MIS_IDX_ENABLE;
    localparam logic [7:0] st_i = `MIS_IDX_STATUS;
    localparam logic [7:0] mc_i = `MIS_IDX_MISC;
    logic core_clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rng;
    logic [2:0] pin_n;
    logic tmr_req, rtc_req, spi_req, rtc_int_used;
    logic [7:0] sav;
    logic [1:0] p_flag, p_rd, p_acc, p_clr;
    mis_cpu_cmd_s cpu_cmd;
    mis_seq_s seq;
    logic [31:0] exp_q[$];
    int failures, total_checks;
    mis_sequencer #(.TMR_VEC(16'h3ff6), .RTC_VEC(16'h3ff2),
        .SPI_VEC(16'h3ff0)) dut (.core_clk(core_clk),
        .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .req_n(pin_n[0]), .ext_line_a_n(pin_n[1]),
        .ext_line_b_n(pin_n[2]), .tmr_req(tmr_req), .rtc_req(rtc_req),
        .spi_req(spi_req), .rtc_int_used(rtc_int_used),
        .periph_flag(p_flag), .periph_status_rd(p_rd),
        .periph_assoc_acc(p_acc), .periph_flag_clr(p_clr),
        .cpu_cmd(cpu_cmd), .seq(seq));
    mis_cpu_model cpu (.core_clk(core_clk), .resetn(resetn),
        .seq(seq), .cpu_cmd(cpu_cmd));
    // =====================================================
    // Helpers.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // For reads d is the expected byte.
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        rng = xs(rng);
        if (!wr) exp_q.push_back({24'h0, d});
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {rng[31:8], d};
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Pulses on one line are always spaced past the write that clears its flag.
    task automatic pulse(input int i);
        pin_n[i] <= 1'b0;
        repeat (4) @(posedge core_clk);
        pin_n[i] <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic ins(input logic [4:0] k);
        rng = xs(rng);
        cpu.run_instr(k, int'(rng[1:0]));
        repeat (3) @(posedge core_clk);
    endtask
    task automatic service(input logic [15:0] v, input logic [7:0] c);
        exp_q.push_back({16'h0, v});
        ins(5'b01000);
        ins(5'b00000);
        if (c != 8'h00) bus(1'b1, st_i, c, 4'h1);
    endtask
    task automatic take(input logic [31:0] v);
        if (exp_q.size() == 0) check(v, 32'hffffffff);
        else check(v, exp_q.pop_front());
    endtask
    // =====================================================
    // Result monitor.
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            take(avs_readdata);
        end
        if (seq.push === 1'b1) begin
            take({16'h0, seq.vector});
        end
    end
    // =====================================================
    // Clock, watchdog and main sequence.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        {avs_read, avs_write, tmr_req, rtc_int_used} = 4'h0;
        {rtc_req, spi_req} = 2'h0;
        avs_address = 10'h000;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
        pin_n = 3'h7;
        {p_flag, p_rd, p_acc} = 6'h00;
        failures = 0;
        total_checks = 0;
        rng = 32'h1447;
        repeat (12) @(posedge core_clk);
        check({seq.mask, seq.load_pc, seq.vector}, 32'h33ffe);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus(1'b0, en_i, 8'h00, 4'hf);
        bus(1'b0, mc_i, 8'h00, 4'hf);
        bus(1'b0, 8'h30, 8'h00, 4'hf);
        sav = rng[15:8];
        bus(1'b1, en_i, sav, 4'h1);
        bus(1'b1, en_i, ~sav, 4'h0);
        bus(1'b0, en_i, sav & 8'hc0, 4'hf);
        bus(1'b1, en_i, 8'h00, 4'h1);
        bus(1'b1, mc_i, 8'hff, 4'h1);
        bus(1'b0, mc_i, 8'he0, 4'hf);
        bus(1'b0, st_i, 8'h03, 4'hf);
        pulse(1);
        bus(1'b0, st_i, 8'h43, 4'hf);
        pulse(2);
        bus(1'b0, st_i, 8'hc3, 4'hf);
        bus(1'b1, st_i, 8'h40, 4'h1);
        bus(1'b0, st_i, 8'h83, 4'hf);
        bus(1'b1, st_i, 8'h80, 4'h1);
        exp_q.push_back(32'h3ffc);
        ins(5'b10000);
        bus(1'b1, en_i, 8'hc0, 4'h1);
        pulse(1);
        ins(5'b00000);
        ins(5'b01100);
        ins(5'b00000);
        service(16'h3ff8, 8'h40);
        check({31'h0, seq.mask}, 32'h1);
        pulse(0);
        pulse(1);
        pulse(2);
        service(16'h3ffa, 8'h00);
        service(16'h3ff8, 8'h00);
        service(16'h3ff8, 8'h40);
        service(16'h3ff4, 8'h80);
        bus(1'b1, mc_i, 8'h40, 4'h1);
        // A level-sensed line held low keeps winning until released.
        pin_n <= 3'h0;
        repeat (4) @(posedge core_clk);
        service(16'h3ffa, 8'h00);
        service(16'h3ffa, 8'h00);
        pin_n <= 3'h1;
        repeat (4) @(posedge core_clk);
        service(16'h3ff8, 8'h40);
        service(16'h3ff4, 8'h80);
        service(16'h3ff4, 8'h80);
        pin_n <= 3'h7;
        repeat (4) @(posedge core_clk);
        bus(1'b1, st_i, 8'hc0, 4'h1);
        bus(1'b0, st_i, 8'h03, 4'hf);
        for (int j = 0; j < 4; j++) begin
            int i;
            i = int'(j[0] ^ rng[0]);
            p_flag[i] <= !j[1];
            p_rd[i] <= 1'b1;
            @(posedge core_clk);
            p_rd <= 2'b00;
            @(posedge core_clk);
            p_acc[i] <= 1'b1;
            @(posedge core_clk);
            check({30'h0, p_clr}, j[1] ? 32'h0 : 32'h1 << i);
            p_acc <= 2'b00;
            p_flag <= 2'b00;
            @(posedge core_clk);
        end
        rtc_int_used <= 1'b1;
        ins(5'b00010);
        check({seq.cpu_clk_run, seq.osc_run}, 32'h0);
        pulse(2);
        check({seq.busy, seq.cpu_clk_run, seq.osc_run}, 32'h3);
        bus(1'b1, st_i, 8'h80, 4'h1);
        rtc_int_used <= 1'b0;
        ins(5'b00010);
        check({seq.cpu_clk_run, seq.osc_run}, 32'h1);
        pulse(1);
        bus(1'b1, st_i, 8'h40, 4'h1);
        ins(5'b01000);
        ins(5'b00001);
        check({seq.cpu_clk_run, seq.osc_run}, 32'h1);
        exp_q.push_back(32'h3ff6);
        {tmr_req, rtc_req, spi_req} <= 3'h7;
        repeat (6) @(posedge core_clk);
        tmr_req <= 1'b0;
        check({31'h0, seq.mask}, 32'h1);
        service(16'h3ff2, 8'h00);
        rtc_req <= 1'b0;
        service(16'h3ff0, 8'h00);
        spi_req <= 1'b0;
        bus(1'b1, en_i, 8'hc0, 4'h1);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({seq.mask, seq.load_pc, seq.vector}, 32'h33ffe);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus(1'b0, en_i, 8'h00, 4'hf);
        repeat (10) @(posedge core_clk);
        check(32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
